// ---- iifr_props.sv ----
// Checker: read-back and summary properties of the isochronous interrupt registers
`timescale 1ns/1ps
`default_nettype none
module iifr_props
    import iso_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic iso_receive_summary_event,
    input wire logic iso_transmit_summary_event,
    input wire logic [iso_irq_pkg::ISO_FAIR_W-1:0] pri_req_limit
);
    logic rd;
    logic wr;
    logic [7:0] a;
    assign a = paddr[7:0];
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    a_ready_high: assert property (psel |-> pready) else $error("pready low");
    a_tx_mask_rsvd:
        assert property (rd && a inside {8'h98, 8'h9c} |-> prdata[31:8] == 24'h0) else $error("tx mask high bits");
    a_rx_rsvd_zero:
        assert property (rd && a inside {[8'ha0:8'hac]} |-> prdata[31:4] == 28'h0) else $error("rx high bits");
    a_fair_rsvd_zero:
        assert property (rd && a == 8'hdc |-> prdata[31:8] == 24'h0) else $error("fairness high bits");
    a_fair_read_back:
        assert property (rd && a == 8'hdc |-> prdata[7:0] == pri_req_limit) else $error("fairness read");
    a_fair_write_takes:
        assert property (wr && a == 8'hdc && pstrb[0] |=> pri_req_limit == $past(pwdata[7:0])) else $error("fair wr");
    a_fair_reset_zero: assert property (!$past(presetn) |-> pri_req_limit == 8'h00) else $error("fair rst");
    a_rx_sum_hold:
        assert property (iso_receive_summary_event && !(wr && a inside {8'ha4, 8'hac}) |=> iso_receive_summary_event)
        else $error("rx summary dropped");
    a_tx_sum_hold:
        assert property (iso_transmit_summary_event && !(wr && a inside {8'h94, 8'h9c}) |=> iso_transmit_summary_event)
        else $error("tx summary dropped");
    c_rx_sum: cover property ($rose(iso_receive_summary_event));
    c_tx_sum: cover property ($rose(iso_transmit_summary_event));
    c_err: cover property (psel && penable && pslverr);
endmodule
bind iso_irq_regs iifr_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .iso_receive_summary_event, .iso_transmit_summary_event, .pri_req_limit);
`default_nettype wire

// ---- iso_interrupt_fairness_regs_tb.sv ----
// Testbench: register, event and interrupt scenarios against a reference model
`timescale 1ns/1ps
`default_nettype none
module iso_interrupt_fairness_regs_tb;
    import iso_irq_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [ISO_RX_N-1:0] rx_ctx_irq = '0;
    logic [ISO_TX_N-1:0] tx_ctx_irq = '0;
    logic pready, pslverr, iso_receive_summary_event, iso_transmit_summary_event, irq, err;
    logic [ISO_FAIR_W-1:0] pri_req_limit;
    logic [31:0] txm = '0, rxm = '0, rxe = '0, txe = '0, fair = '0;
    logic [7:0] amap [9] = '{8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hdc, 8'h90, 8'h94};
    int error_cnt = 0;
    int comparisons = 0;
    always #5 pclk = ~pclk;
    iso_irq_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .rx_ctx_irq, .tx_ctx_irq, .iso_receive_summary_event, .iso_transmit_summary_event,
        .pri_req_limit, .irq);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Ends one idle cycle after the access so the next call never re-drives psel in the same step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            8'h98: txm |= d & 32'hff;
            8'h9c: txm &= ~d;
            8'ha0: rxe |= d & 32'hf;
            8'ha4: rxe &= ~d;
            8'ha8: rxm |= d & 32'hf;
            8'hac: rxm &= ~d;
            8'hdc: fair = d & 32'hff;
            8'h90: txe |= d & 32'hff;
            8'h94: txe &= ~d;
            default: ;
        endcase
        chk(pri_req_limit, fair);
        chk(iso_receive_summary_event, |(rxe & rxm));
        chk(iso_transmit_summary_event, |(txe & txm));
    endtask
    function automatic logic [31:0] expv(input logic [7:0] a);
        case (a)
            8'h98, 8'h9c: return txm;
            8'ha0: return rxe;
            8'ha4: return rxe & rxm;
            8'ha8, 8'hac: return rxm;
            8'hdc: return fair;
            8'h90: return txe;
            default: return txe & txm;
        endcase
    endfunction
    task automatic rdall;
        foreach (amap[i]) begin
            apb(1'b0, amap[i], 32'h0);
            chk(rd, expv(amap[i]));
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        final_report();
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'hc1ca));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdall();
        for (int i = 0; i < 40; i++) begin
            wr(amap[$urandom_range(8)], $urandom());
            if (i % 10 == 9) rdall();
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        foreach (amap[i]) wr(amap[i], (i % 2 == 1) ? 32'hffffffff : 32'h0);
        apb(1'b1, 8'hf4, 32'h3);
        apb(1'b1, 8'hf8, 32'h3);
        chk(irq, 1'b0);
        wr(8'ha8, 32'h4);
        rx_ctx_irq <= 4'h4;
        repeat (3) @(posedge pclk);
        rxe |= 32'h4;
        chk({iso_receive_summary_event, irq}, 2'b11);
        apb(1'b1, 8'hf8, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, 8'hf4, 32'h1);
        apb(1'b1, 8'hf8, 32'h3);
        chk({iso_receive_summary_event, irq}, 2'b10);
        wr(8'h98, 32'h80);
        tx_ctx_irq <= 8'h80;
        repeat (3) @(posedge pclk);
        txe |= 32'h80;
        chk({iso_transmit_summary_event, irq}, 2'b11);
        apb(1'b0, 8'hf0, 32'h0);
        chk(rd, 32'h2);
        rdall();
        rx_ctx_irq <= '0;
        tx_ctx_irq <= '0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {txm, rxm, rxe, txe, fair} = '0;
        @(posedge pclk);
        chk(irq, 1'b0);
        rdall();
        final_report();
    end
endmodule
`default_nettype wire

// ---- iso_irq_edge.sv ----
// Rising-edge detector for per-context completion signals
`timescale 1ns/1ps
`default_nettype none
module iso_irq_edge #(
    parameter int N = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] level,
    output logic [N-1:0] rise
);
    logic [N-1:0] prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end
    assign rise = level & ~prev_q;
endmodule
`default_nettype wire

// ---- iso_irq_pkg.sv ----
// Package: register map, field widths and reset values of the isochronous interrupt block
package iso_irq_pkg;
    localparam int ISO_ADDR_W = 8;
    localparam logic [7:0] ISO_TX_MASK_SET_OFS = 8'h98;
    localparam logic [7:0] ISO_TX_MASK_CLR_OFS = 8'h9c;
    localparam logic [7:0] ISO_RX_EVT_SET_OFS = 8'ha0;
    localparam logic [7:0] ISO_RX_EVT_CLR_OFS = 8'ha4;
    localparam logic [7:0] ISO_RX_MASK_SET_OFS = 8'ha8;
    localparam logic [7:0] ISO_RX_MASK_CLR_OFS = 8'hac;
    localparam logic [7:0] ISO_FAIR_OFS = 8'hdc;
    localparam logic [7:0] ISO_TX_EVT_SET_OFS = 8'h90;
    localparam logic [7:0] ISO_TX_EVT_CLR_OFS = 8'h94;
    localparam logic [7:0] ISO_IRQ_STAT_OFS = 8'hf0;
    localparam logic [7:0] ISO_IRQ_CLR_OFS = 8'hf4;
    localparam logic [7:0] ISO_IRQ_EN_OFS = 8'hf8;
    localparam int ISO_TX_N = 8;
    localparam int ISO_RX_N = 4;
    localparam int ISO_FAIR_W = 8;
    localparam int ISO_STAT_W = 2;
    localparam int ISO_STAT_RX = 0;
    localparam int ISO_STAT_TX = 1;
    localparam logic [ISO_TX_N-1:0] ISO_TX_MASK_RST = 8'h00;
    localparam logic [ISO_RX_N-1:0] ISO_RX_MASK_RST = 4'h0;
    localparam logic [ISO_RX_N-1:0] ISO_RX_EVT_RST = 4'h0;
    localparam logic [ISO_FAIR_W-1:0] ISO_FAIR_RST = 8'h00;
endpackage

// ---- iso_irq_regs.sv ----
// Isochronous per-context interrupt registers, fairness limit and APB slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: Transmit mask has set and clear aliases
// RL2: Mask alias reads return stored mask
// RL3: Transmit mask eight bits, upper bits zero
// RL4: Receive completion with irq raises event
// RL5: Rising edge or set write sets event
// RL6: Only clear-alias write one clears event
// RL7: Clear alias read gives event AND mask
// RL8: Receive event bits 3..0 only
// RL9: Event bit n names receive channel n
// RL10: Four-bit receive mask with set/clear aliases
// RL11: Fairness field limits priority requests
// RL12: Fairness resets zero, upper bits zero
// RL13: Transmit clear alias read ANDs mask
// RL14: Summaries drive from masked event bits
module iso_irq_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [iso_irq_pkg::ISO_RX_N-1:0] rx_ctx_irq,
    input wire logic [iso_irq_pkg::ISO_TX_N-1:0] tx_ctx_irq,
    output logic iso_receive_summary_event,
    output logic iso_transmit_summary_event,
    output logic [iso_irq_pkg::ISO_FAIR_W-1:0] pri_req_limit,
    output logic irq
);
    import iso_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wr;
    logic rd;
    logic [ISO_ADDR_W-1:0] ofs;
    logic hit;
    logic [31:0] wmask;
    assign ofs = paddr[ISO_ADDR_W-1:0];
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end
    always_comb begin
        hit = 1'b0;
        if (paddr[31:ISO_ADDR_W] == '0) begin
            unique case (ofs)
                ISO_TX_MASK_SET_OFS, ISO_TX_MASK_CLR_OFS, ISO_RX_EVT_SET_OFS, ISO_RX_EVT_CLR_OFS,
                ISO_RX_MASK_SET_OFS, ISO_RX_MASK_CLR_OFS, ISO_FAIR_OFS, ISO_TX_EVT_SET_OFS,
                ISO_TX_EVT_CLR_OFS, ISO_IRQ_STAT_OFS, ISO_IRQ_CLR_OFS, ISO_IRQ_EN_OFS: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end
    assign pslverr = psel & penable & ~hit;

    logic [31:0] wd;
    assign wd = pwdata & wmask;
    function automatic logic sel(input logic [ISO_ADDR_W-1:0] o);
        sel = wr & hit & (ofs == o);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event and mask banks
    logic [ISO_RX_N-1:0] rx_rise;
    logic [ISO_TX_N-1:0] tx_rise;
    logic [ISO_RX_N-1:0] rx_evt;
    logic [ISO_TX_N-1:0] tx_evt;
    logic [ISO_RX_N-1:0] rx_mask;
    logic [ISO_TX_N-1:0] tx_mask;

    // Completion flags come from logic on pclk, so no synchroniser
    iso_irq_edge #(.N(ISO_RX_N)) u_rx_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(rx_ctx_irq),
        .rise(rx_rise)
    );
    iso_irq_edge #(.N(ISO_TX_N)) u_tx_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(tx_ctx_irq),
        .rise(tx_rise)
    );

    // Bit n tracks receive channel n (see RL9); edge or set write sets it (see RL4) (see RL5)
    iso_irq_w1sc #(.N(ISO_RX_N), .RST(ISO_RX_EVT_RST)) u_rx_evt (
        .pclk(pclk),
        .presetn(presetn),
        .set(rx_rise | ({ISO_RX_N{sel(ISO_RX_EVT_SET_OFS)}} & wd[ISO_RX_N-1:0])),
        .clr({ISO_RX_N{sel(ISO_RX_EVT_CLR_OFS)}} & wd[ISO_RX_N-1:0]), // see RL6
        .value(rx_evt)
    );
    iso_irq_w1sc #(.N(ISO_TX_N), .RST(ISO_TX_MASK_RST)) u_tx_evt (
        .pclk(pclk),
        .presetn(presetn),
        .set(tx_rise | ({ISO_TX_N{sel(ISO_TX_EVT_SET_OFS)}} & wd[ISO_TX_N-1:0])),
        .clr({ISO_TX_N{sel(ISO_TX_EVT_CLR_OFS)}} & wd[ISO_TX_N-1:0]),
        .value(tx_evt)
    );
    // Mask aliases: ones set via set alias, ones clear via clear alias (see RL1) (see RL10)
    iso_irq_w1sc #(.N(ISO_TX_N), .RST(ISO_TX_MASK_RST)) u_tx_mask (
        .pclk(pclk),
        .presetn(presetn),
        .set({ISO_TX_N{sel(ISO_TX_MASK_SET_OFS)}} & wd[ISO_TX_N-1:0]),
        .clr({ISO_TX_N{sel(ISO_TX_MASK_CLR_OFS)}} & wd[ISO_TX_N-1:0]),
        .value(tx_mask)
    );
    iso_irq_w1sc #(.N(ISO_RX_N), .RST(ISO_RX_MASK_RST)) u_rx_mask (
        .pclk(pclk),
        .presetn(presetn),
        .set({ISO_RX_N{sel(ISO_RX_MASK_SET_OFS)}} & wd[ISO_RX_N-1:0]),
        .clr({ISO_RX_N{sel(ISO_RX_MASK_CLR_OFS)}} & wd[ISO_RX_N-1:0]),
        .value(rx_mask)
    );

    // Summaries are combinational so they follow the registers without delay
    assign iso_receive_summary_event = |(rx_evt & rx_mask); // see RL14
    assign iso_transmit_summary_event = |(tx_evt & tx_mask); // see RL14

    ////////////////////////////////////////////////////////////////////////////
    // Fairness limit
    logic [ISO_FAIR_W-1:0] fair_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fair_q <= ISO_FAIR_RST; // see RL12
        end else if (sel(ISO_FAIR_OFS) && pstrb[0]) begin
            fair_q <= pwdata[ISO_FAIR_W-1:0]; // see RL11
        end
    end
    assign pri_req_limit = fair_q; // see RL11

    ////////////////////////////////////////////////////////////////////////////
    // Summary interrupt status, clear and enable
    logic [ISO_STAT_W-1:0] stat_q;
    logic [ISO_STAT_W-1:0] en_q;
    logic [ISO_STAT_W-1:0] sum_now;
    logic [ISO_STAT_W-1:0] sum_prev_q;
    logic [ISO_STAT_W-1:0] stat_set;
    logic [ISO_STAT_W-1:0] stat_clr;
    assign sum_now[ISO_STAT_RX] = iso_receive_summary_event;
    assign sum_now[ISO_STAT_TX] = iso_transmit_summary_event;
    assign stat_set = sum_now & ~sum_prev_q;
    assign stat_clr = {ISO_STAT_W{sel(ISO_IRQ_CLR_OFS)}} & wd[ISO_STAT_W-1:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_prev_q <= '0;
        end else begin
            sum_prev_q <= sum_now;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
        end else if (sel(ISO_IRQ_EN_OFS)) begin
            en_q <= wd[ISO_STAT_W-1:0];
        end
    end
    assign irq = |(stat_q & en_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reads never alter any state (see RL6)
    always_comb begin
        prdata = '0;
        if (rd && hit) begin
            unique case (ofs)
                ISO_TX_MASK_SET_OFS, ISO_TX_MASK_CLR_OFS: prdata[ISO_TX_N-1:0] = tx_mask; // see RL2 (see RL3)
                ISO_RX_MASK_SET_OFS, ISO_RX_MASK_CLR_OFS: prdata[ISO_RX_N-1:0] = rx_mask; // see RL2
                ISO_RX_EVT_SET_OFS: prdata[ISO_RX_N-1:0] = rx_evt; // see RL8
                ISO_RX_EVT_CLR_OFS: prdata[ISO_RX_N-1:0] = rx_evt & rx_mask; // see RL7
                ISO_TX_EVT_SET_OFS: prdata[ISO_TX_N-1:0] = tx_evt;
                ISO_TX_EVT_CLR_OFS: prdata[ISO_TX_N-1:0] = tx_evt & tx_mask; // see RL13
                ISO_FAIR_OFS: prdata[ISO_FAIR_W-1:0] = fair_q; // see RL12
                ISO_IRQ_STAT_OFS: prdata[ISO_STAT_W-1:0] = stat_q;
                ISO_IRQ_EN_OFS: prdata[ISO_STAT_W-1:0] = en_q;
                default: prdata = '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- iso_irq_w1sc.sv ----
// Set/clear alias register bank with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module iso_irq_w1sc #(
    parameter int N = 4,
    parameter logic [N-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] value
);
    logic [N-1:0] val_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_q <= RST;
        end else begin
            // A set in the same cycle as a clear wins
            val_q <= (val_q & ~clr) | set;
        end
    end
    assign value = val_q;
endmodule
`default_nettype wire
